// [design/burst_sram_pkg.sv]
// shared constants and carrier types for the burst sram control block
`default_nettype none
package burst_sram_pkg;
  // ==========================================================
  // geometry
  localparam int ADDR_W    = 18;        // word address width
  localparam int DATA_W    = 16;        // data lines
  localparam int LANES     = 2;         // byte lanes, one parity bit each
  localparam int LANE_W    = 8;         // bits per lane
  localparam int BURST_W   = 2;         // burst counter width
  // ==========================================================
  // timing
  localparam int CLK_HZ          = 10_000_000; // clk_i rate
  localparam int SLEEP_CYC       = 2;          // cycles to enter or leave
  localparam int SLEEP_CNT_W     = 2;          // width of sleep counter
  localparam int SYNC_STAGES     = 3;          // pin synchroniser depth
  // ==========================================================
  // reset values
  localparam logic [1:0] BURST_RST = 2'h0;     // counter after reset

  // sleep sequencing states
  typedef enum logic [1:0] {
    SLP_AWAKE    = 2'b00,
    SLP_ENTERING = 2'b01,
    SLP_ASLEEP   = 2'b10,
    SLP_WAKING   = 2'b11
  } sleep_state_t;

  // write controls as sampled
  typedef struct packed {
    logic                 global_write_n;
    logic                 byte_write_enable_n;
    logic [LANES-1:0]     byte_lane_select_n;
  } write_ctl_t;

  // selects and strobes as sampled
  typedef struct packed {
    logic chip_sel_a_n;
    logic chip_sel_b;
    logic chip_sel_c_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_step_n;
  } access_ctl_t;
endpackage : burst_sram_pkg
`default_nettype wire

// [design/burst_order_step.sv]
// next burst address for linear or interleaved order
`default_nettype none
module burst_order_step (
  // burst state
  input  wire logic [1:0] start_i,      // first two address bits
  input  wire logic [1:0] index_i,      // position within the burst
  input  wire logic       interleave_i, // high selects interleaved order
  // result
  output logic      [1:0] addr_o        // two low address bits to use
);
  // ==========================================================
  // order selection
  // interleaved xors the index in, linear adds it modulo four
  always_comb begin
    if (interleave_i) begin
      addr_o = start_i ^ index_i; // R15
    end else begin
      addr_o = 2'(start_i + index_i); // R16
    end
  end
endmodule : burst_order_step
`default_nettype wire

// [design/sync_burst_sram_control.sv]
// control logic of a pipelined burst sram with common i/o
`default_nettype none
// What this block does
// (R1) register all synchronous inputs on rising clock
// (R2) read starts on selects plus either strobe
// (R3) controller-strobe read: far end holds writes off
// (R4) load address register and counter at start
// (R5) drive read data only while output_drive_n low
// (R6) processor-strobe start ignores writes first cycle
// (R7) controller strobe write when processor strobe high
// (R8) byte writes gated by byte enable and lanes
// (R9) lane 0 low byte, lane 1 high byte
// (R10) global write writes every lane
// (R11) outputs released whenever a write is seen
// (R12) far end releases output enable before writing
// (R13) two-bit wrap burst counter from low address
// (R14) order pin: low linear, high interleaved
// (R15) interleaved: start xor index
// (R16) linear: start plus index modulo four
// (R17) sleep input: retain array, two-cycle transitions
// (R18) access pending at sleep entry is invalid
// (R19) far end deselects around sleep and recovery
// (R20) burst_step_n low advances, high suspends
// (R21) write when global or byte enable with lane
module sync_burst_sram_control #(
  parameter int ADDR_W = burst_sram_pkg::ADDR_W, // word address width
  parameter int DATA_W = burst_sram_pkg::DATA_W, // data width
  parameter int LANES  = burst_sram_pkg::LANES   // byte lanes
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // address and selects
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              chip_sel_a_n_i,
  input  wire logic              chip_sel_b_i,
  input  wire logic              chip_sel_c_n_i,
  input  wire logic              processor_addr_strobe_n_i,
  input  wire logic              controller_addr_strobe_n_i,
  input  wire logic              burst_step_n_i,
  // write controls
  input  wire logic              global_write_n_i,
  input  wire logic              byte_write_enable_n_i,
  input  wire logic [LANES-1:0]  byte_lane_select_n_i,
  // asynchronous controls
  input  wire logic              output_drive_n_i,
  input  wire logic              sleep_request_i,
  input  wire logic              burst_order_select_i,
  // shared data and parity lines
  input  wire logic [DATA_W-1:0] data_in_i,
  output logic      [DATA_W-1:0] data_out_o,
  output logic                   data_oe_o,
  input  wire logic [LANES-1:0]  parity_in_i,
  output logic      [LANES-1:0]  parity_out_o,
  output logic                   parity_oe_o,
  // status
  output logic                   asleep_o,
  output logic                   access_invalid_o
);
  localparam int LW = burst_sram_pkg::LANE_W;
  localparam int WORDS = 1 << ADDR_W;
  localparam int SN = burst_sram_pkg::SYNC_STAGES;

  // ==========================================================
  // helper functions
  // write decode: global wins, else byte enable with any lane
  function automatic logic is_write(input burst_sram_pkg::write_ctl_t w);
    is_write = !w.global_write_n ||
               (!w.byte_write_enable_n && !(&w.byte_lane_select_n)); // R21
  endfunction : is_write

  // per-lane write mask from sampled controls
  function automatic logic [LANES-1:0] lane_mask(
    input burst_sram_pkg::write_ctl_t w);
    if (!w.global_write_n) begin
      lane_mask = '1; // R10
    end else if (!w.byte_write_enable_n) begin
      lane_mask = ~w.byte_lane_select_n; // R8
    end else begin
      lane_mask = '0;
    end
  endfunction : lane_mask

  // ==========================================================
  // input registers
  burst_sram_pkg::access_ctl_t acc_ff;   // sampled selects and strobes
  burst_sram_pkg::write_ctl_t  wctl_ff;  // sampled write controls
  logic [ADDR_W-1:0]           addr_ff;  // sampled address
  logic [DATA_W-1:0]           din_ff;   // sampled write data
  logic [LANES-1:0]            pin_ff;   // sampled write parity

  // capture every synchronous input on the rising edge
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      acc_ff  <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
      wctl_ff <= '{1'b1, 1'b1, '1};
      addr_ff <= '0;
      din_ff  <= '0;
      pin_ff  <= '0;
    end else begin
      acc_ff  <= '{chip_sel_a_n_i, chip_sel_b_i, chip_sel_c_n_i,
                   processor_addr_strobe_n_i,
                   controller_addr_strobe_n_i, burst_step_n_i}; // R1
      wctl_ff <= '{global_write_n_i, byte_write_enable_n_i,
                   byte_lane_select_n_i}; // R1
      addr_ff <= addr_i; // R1
      din_ff  <= data_in_i; // R1
      pin_ff  <= parity_in_i; // R1
    end
  end

  // ==========================================================
  // pin synchronisers for the asynchronous levels
  // sleep and order are asynchronous; only stages 2 and 3 are read
  logic [SN-1:0] slp_sync_ff;  // sleep request chain
  logic [SN-1:0] ord_sync_ff;  // order select chain
  logic          sleep_lvl_ff; // filtered sleep level
  logic          order_lvl_ff; // filtered order level, high interleaved

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      slp_sync_ff <= '0;
      ord_sync_ff <= '1; // unconnected order pin defaults high
    end else begin
      slp_sync_ff <= {slp_sync_ff[SN-2:0], sleep_request_i};
      ord_sync_ff <= {ord_sync_ff[SN-2:0], burst_order_select_i};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sleep_lvl_ff <= 1'b0;
      order_lvl_ff <= 1'b1; // R14
    end else begin
      if (slp_sync_ff[SN-1] == slp_sync_ff[SN-2]) begin
        sleep_lvl_ff <= slp_sync_ff[SN-1];
      end
      if (ord_sync_ff[SN-1] == ord_sync_ff[SN-2]) begin
        order_lvl_ff <= ord_sync_ff[SN-1]; // R14
      end
    end
  end

  // ==========================================================
  // sleep sequencing
  burst_sram_pkg::sleep_state_t slp_ff;     // sleep state
  burst_sram_pkg::sleep_state_t nxt_slp;    // next sleep state
  logic [burst_sram_pkg::SLEEP_CNT_W-1:0] slp_cnt_ff; // transition count
  logic          awake;                     // accesses allowed

  assign awake = (slp_ff == burst_sram_pkg::SLP_AWAKE);

  // each transition lasts two cycles before it takes effect
  always_comb begin
    nxt_slp = slp_ff;
    case (slp_ff)
      burst_sram_pkg::SLP_AWAKE: begin
        if (sleep_lvl_ff) nxt_slp = burst_sram_pkg::SLP_ENTERING;
      end
      burst_sram_pkg::SLP_ENTERING: begin
        if (slp_cnt_ff == 2'(burst_sram_pkg::SLEEP_CYC - 1)) begin
          nxt_slp = burst_sram_pkg::SLP_ASLEEP; // R17
        end
      end
      burst_sram_pkg::SLP_ASLEEP: begin
        if (!sleep_lvl_ff) nxt_slp = burst_sram_pkg::SLP_WAKING;
      end
      burst_sram_pkg::SLP_WAKING: begin
        if (slp_cnt_ff == 2'(burst_sram_pkg::SLEEP_CYC - 1)) begin
          nxt_slp = burst_sram_pkg::SLP_AWAKE; // R17
        end
      end
      default: nxt_slp = burst_sram_pkg::SLP_AWAKE;
    endcase
  end

  // state and transition counter
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      slp_ff     <= burst_sram_pkg::SLP_AWAKE;
      slp_cnt_ff <= '0;
    end else begin
      slp_ff <= nxt_slp;
      if (nxt_slp != slp_ff) slp_cnt_ff <= '0;
      else slp_cnt_ff <= 2'(slp_cnt_ff + 2'h1);
    end
  end

  assign asleep_o = !awake;

  // ==========================================================
  // access decode on the sampled inputs
  logic sel_all;   // all three selects active
  logic ps_start;  // processor strobe start
  logic cs_start;  // controller strobe start
  logic start;     // any new access
  logic start_wr;  // start is a controller strobe write
  logic cont;      // no strobe: burst continues or suspends

  assign sel_all  = !acc_ff.chip_sel_a_n && acc_ff.chip_sel_b &&
                    !acc_ff.chip_sel_c_n;
  // processor strobe is dropped while select a is high
  assign ps_start = awake && sel_all &&
                    !acc_ff.processor_addr_strobe_n; // R2
  // controller strobe ignored while processor strobe is low
  assign cs_start = awake && sel_all && !acc_ff.controller_addr_strobe_n &&
                    acc_ff.processor_addr_strobe_n; // R7
  assign start    = ps_start || cs_start; // R2
  assign start_wr = cs_start && is_write(wctl_ff); // R7
  // continue needs controller strobe high; processor strobe high or masked
  assign cont     = awake && acc_ff.controller_addr_strobe_n &&
                    (acc_ff.processor_addr_strobe_n || acc_ff.chip_sel_a_n);

  // ==========================================================
  // address register and burst counter
  logic [ADDR_W-1:0]  base_ff;   // latched address
  logic [1:0]         idx_ff;    // position within burst
  logic [1:0]         nxt_idx;   // position used by this cycle
  logic               active_ff; // a burst is open
  logic [1:0]         low_bits;  // current two low address bits
  logic [ADDR_W-1:0]  cur_addr;  // address applied to the array

  // a sampled step moves to the next address in that same cycle,
  // otherwise the first continue beat would repeat the start word
  assign nxt_idx = (cont && active_ff && !acc_ff.burst_step_n)
                 ? 2'(idx_ff + 2'h1) : idx_ff; // R20

  burst_order_step u_step (
    .start_i      (base_ff[1:0]),
    .index_i      (nxt_idx),
    .interleave_i (order_lvl_ff),
    .addr_o       (low_bits)
  );

  // wrap-around counter; step low advances, high holds
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      base_ff   <= '0;
      idx_ff    <= burst_sram_pkg::BURST_RST;
      active_ff <= 1'b0;
    end else if (!awake) begin
      active_ff <= 1'b0; // R18
    end else if (start) begin
      base_ff   <= addr_ff; // R4
      idx_ff    <= burst_sram_pkg::BURST_RST; // R13
      active_ff <= 1'b1;
    end else if (cont && active_ff) begin
      idx_ff <= nxt_idx; // R20
    end
  end

  // new start uses the fresh address straight away
  assign cur_addr = start ? addr_ff
                          : {base_ff[ADDR_W-1:2], low_bits}; // R4 R13

  // ==========================================================
  // array access
  logic [DATA_W+LANES-1:0] mem_ff [WORDS]; // array, word plus parity
  logic                    do_write;       // write this cycle
  logic [LANES-1:0]        wmask;          // lanes written
  logic                    rd_valid_ff;    // read data pending on pins
  logic [DATA_W-1:0]       rdata_ff;       // read data register
  logic [LANES-1:0]        rpar_ff;        // read parity register

  // processor-strobe start never writes; later cycles may
  assign do_write = start_wr ||
                    (cont && active_ff && is_write(wctl_ff)); // R6 R7
  assign wmask    = lane_mask(wctl_ff);

  // lane writes; array keeps contents through sleep
  always_ff @(posedge clk_i) begin
    if (do_write) begin
      for (int l = 0; l < LANES; l++) begin
        if (wmask[l]) begin
          mem_ff[cur_addr][l*LW +: LW] <= din_ff[l*LW +: LW]; // R9
          mem_ff[cur_addr][DATA_W+l]   <= pin_ff[l]; // R9
        end
      end
    end
  end

  // read register follows the access address
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rd_valid_ff <= 1'b0;
      rdata_ff    <= '0;
      rpar_ff     <= '0;
    end else begin
      rd_valid_ff <= (start || (cont && active_ff)) && !do_write;
      if ((start || (cont && active_ff)) && !do_write) begin
        {rpar_ff, rdata_ff} <= mem_ff[cur_addr];
      end
    end
  end

  // ==========================================================
  // output drive and status
  logic wr_seen_ff; // write detected, hold pins released

  always_ff @(posedge clk_i) begin
    if (!nrst_i) wr_seen_ff <= 1'b0;
    else wr_seen_ff <= do_write;
  end

  // output enable is asynchronous: gates drive without sampling
  assign data_oe_o   = rd_valid_ff && !wr_seen_ff && !do_write &&
                       !output_drive_n_i && awake; // R5 R11
  assign parity_oe_o = data_oe_o; // R11
  assign data_out_o  = rdata_ff;
  assign parity_out_o = rpar_ff;
  // pulse when sleep cut an open burst short
  always_ff @(posedge clk_i) begin
    if (!nrst_i) access_invalid_o <= 1'b0;
    else access_invalid_o <= active_ff && !awake; // R18
  end
endmodule : sync_burst_sram_control
`default_nettype wire

// [bench/far_end_model.sv]
// far-end model that resolves the shared data and parity wires
`default_nettype none
module far_end_model (
  // device side
  input  wire logic        clk_i,
  input  wire logic [17:0] dev_q_i,  // {parity, data} from the device
  input  wire logic        dev_oe_i, // device drives the lines
  // host side
  input  wire logic        drv_en_i, // host drives write data
  input  wire logic [17:0] drv_q_i,  // host write data
  output logic      [17:0] wire_o    // resolved line level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] last_ff; // previous level
  // remember the level so floating lines can show its inverse
  always_ff @(posedge clk_i) begin
    last_ff <= wire_o;
  end
  // host only drives once the device has let go of the lines
  always_comb begin
    if (dev_oe_i) wire_o = dev_q_i;
    else if (drv_en_i) wire_o = drv_q_i;
    else wire_o = ~last_ff; // floating: never a stale copy
  end
endmodule : far_end_model
`default_nettype wire

// [bench/sram_ctl_props.sv]
// port-level timing checks for the burst sram control block
`default_nettype none
module sram_ctl_props #(
  parameter int LANES = 2 // byte lanes
) (
  // clock, selects and strobes
  input wire logic             clk_i, nrst_i, chip_sel_a_n_i, chip_sel_b_i,
  input wire logic             chip_sel_c_n_i, processor_addr_strobe_n_i,
  input wire logic             controller_addr_strobe_n_i,
  // write and asynchronous controls
  input wire logic             global_write_n_i, byte_write_enable_n_i,
  input wire logic [LANES-1:0] byte_lane_select_n_i,
  input wire logic             output_drive_n_i, sleep_request_i,
  // outputs watched
  input wire logic             data_oe_o, parity_oe_o, asleep_o,
  input wire logic             access_invalid_o
);
  logic sel;    // all three selects active
  logic wr_req; // write controls ask for a write
  assign sel = !chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i;
  assign wr_req = !global_write_n_i ||
                  (!byte_write_enable_n_i && !(&byte_lane_select_n_i));
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================
  // access starts
  sequence p_start;
    sel && !processor_addr_strobe_n_i && !asleep_o;
  endsequence
  sequence c_write;
    sel && processor_addr_strobe_n_i && !controller_addr_strobe_n_i &&
      wr_req && !asleep_o;
  endsequence
  sequence p_write;
    p_start ##1 (processor_addr_strobe_n_i && controller_addr_strobe_n_i &&
      wr_req);
  endsequence
  // ==========================================================
  // properties
  AST_OE_GATE: assert property (output_drive_n_i |-> !data_oe_o)
    else $error("lines driven with output enable off");
  AST_PARITY_TIED: assert property (parity_oe_o == data_oe_o)
    else $error("parity enable differs from data enable");
  AST_CWRITE_RELEASE: assert property (c_write |-> ##1 !data_oe_o [*2])
    else $error("lines driven during controller write");
  AST_PWRITE_RELEASE: assert property (p_write |-> ##1 !data_oe_o [*2])
    else $error("lines driven during processor write");
  AST_READ_DRIVE: assert property
    (p_start ##1 !wr_req ##1 (!output_drive_n_i && !asleep_o) |-> data_oe_o)
    else $error("read data not driven");
  AST_SLEEP_ENTER: assert property (sleep_request_i [*8] |-> asleep_o)
    else $error("sleep not entered");
  AST_SLEEP_WAKE: assert property (!sleep_request_i [*8] |-> !asleep_o)
    else $error("sleep not left");
  AST_SLEEP_SLOW: assert property ($rose(asleep_o) |->
    $past(sleep_request_i, 1) && $past(sleep_request_i, 2))
    else $error("sleep entered too early");
  AST_SNOOZE_HIZ: assert property
    (asleep_o && $past(asleep_o, 2) |-> !data_oe_o)
    else $error("lines driven while asleep");
  AST_INVALID_SLEEP: assert property
    (access_invalid_o |-> asleep_o ##1 !access_invalid_o)
    else $error("invalid flag outside sleep entry");
endmodule : sram_ctl_props
bind sync_burst_sram_control sram_ctl_props #(.LANES(LANES)) props_u (
  .clk_i(clk_i), .nrst_i(nrst_i), .chip_sel_a_n_i(chip_sel_a_n_i),
  .chip_sel_b_i(chip_sel_b_i), .chip_sel_c_n_i(chip_sel_c_n_i),
  .processor_addr_strobe_n_i(processor_addr_strobe_n_i),
  .controller_addr_strobe_n_i(controller_addr_strobe_n_i),
  .global_write_n_i(global_write_n_i),
  .byte_write_enable_n_i(byte_write_enable_n_i),
  .byte_lane_select_n_i(byte_lane_select_n_i),
  .output_drive_n_i(output_drive_n_i), .sleep_request_i(sleep_request_i),
  .data_oe_o(data_oe_o), .parity_oe_o(parity_oe_o), .asleep_o(asleep_o),
  .access_invalid_o(access_invalid_o));
`default_nettype wire

// [bench/sync_burst_sram_control_bench.sv]
// self-checking bench for the burst sram control block
`default_nettype none
module sync_burst_sram_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, csa_n, csb, csc_n, ps_n, cs_n, step_n, gw_n, bwe_n;
  logic od_n, slp, mode, drv_en, doe, poe, asleep, inval;
  logic [1:0]  lane_n, pq;
  logic [15:0] dq;
  logic [17:0] addr, drv_q, wq, base;
  logic [17:0] mem [4];                                // expected words
  logic [3:0]  wtab [4] = '{4'ha, 4'h9, 4'hb, 4'h3};   // lane corners
  int          failures, comparisons;
  int          inval_cnt;                              // invalid pulses seen
  integer      seed;
  sync_burst_sram_control dut_u (
    .clk_i(clk), .nrst_i(nrst), .addr_i(addr), .chip_sel_a_n_i(csa_n),
    .chip_sel_b_i(csb), .chip_sel_c_n_i(csc_n),
    .processor_addr_strobe_n_i(ps_n), .controller_addr_strobe_n_i(cs_n),
    .burst_step_n_i(step_n), .global_write_n_i(gw_n),
    .byte_write_enable_n_i(bwe_n), .byte_lane_select_n_i(lane_n),
    .output_drive_n_i(od_n), .sleep_request_i(slp),
    .burst_order_select_i(mode), .data_in_i(wq[15:0]), .data_out_o(dq),
    .data_oe_o(doe), .parity_in_i(wq[17:16]), .parity_out_o(pq),
    .parity_oe_o(poe), .asleep_o(asleep), .access_invalid_o(inval));
  far_end_model far_u (.clk_i(clk), .dev_q_i({pq, dq}), .dev_oe_i(doe),
    .drv_en_i(drv_en), .drv_q_i(drv_q), .wire_o(wq));
  // ==========================================================
  // expectations
  function automatic logic [17:0] merge(input logic [17:0] o, n,
                                        input logic [3:0] w);
    logic [17:0] m;
    m = {~w[1], ~w[0], {8{~w[1]}}, {8{~w[0]}}};
    if (!w[3]) m = 18'h3ffff;
    else if (w[2]) m = 18'h0;
    return (n & m) | (o & ~m);
  endfunction : merge
  function automatic logic [1:0] lo(input logic [1:0] s, i);
    return mode ? s ^ i : s + i;
  endfunction : lo
  // ==========================================================
  // drivers and checks
  task automatic cmp(input string what, input logic [17:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic final_report();
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // deselected, strobes high, nothing driven by the host
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk);
      {csa_n, csb, csc_n, ps_n, cs_n, step_n, gw_n, bwe_n} = 8'hbf;
      lane_n = 2'h3;
      drv_en = 1'b0;
    end
  endtask : idle
  // one start cycle; w is {global, byte enable, lanes}, active low
  task automatic start(input logic [17:0] a, d, input logic p, c,
                       input logic [3:0] w);
    @(negedge clk);
    {csa_n, csb, csc_n, ps_n, cs_n, step_n} = {3'b010, p, c, 1'b1};
    {gw_n, bwe_n, lane_n} = w;
    addr = a;
    drv_q = d;
  endtask : start
  // write word k; pstart opens with the processor strobe first
  task automatic wr(input int k, input logic [17:0] d,
                    input logic [3:0] w, input logic pstart);
    od_n = 1'b1;
    if (pstart) begin
      start({base[17:2], 2'(k)}, d, 1'b0, 1'b1, 4'h0);
      @(negedge clk);
      {csa_n, ps_n, cs_n} = 3'h7;
      {gw_n, bwe_n, lane_n} = w;
    end else start({base[17:2], 2'(k)}, d, 1'b1, 1'b0, w);
    drv_en = 1'b1;
    mem[k] = merge(mem[k], d, w);
    idle(3);
  endtask : wr
  // burst from word s with random suspends, every beat checked
  task automatic rd(input logic [1:0] s);
    logic [1:0] idx;
    idx = 2'h0;
    od_n = 1'b0;
    start({base[17:2], s}, 18'h0, s[0], ~s[0], 4'hf);
    @(negedge clk);
    {csa_n, ps_n, cs_n, step_n} = 4'he;
    repeat (6) begin
      @(negedge clk);
      cmp("beat", mem[lo(s, idx)], wq);
      if (!step_n) idx++;
      step_n = 1'($random(seed));
    end
    od_n = 1'b1;
    #1;
    cmp("enable", 18'h0, {16'h0, poe, doe});
    idle(3);
  endtask : rd
  // ==========================================================
  // clock, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    seed = 32'hce26;
    {nrst, slp, mode, drv_en, od_n} = 5'h05;
    {csa_n, csb, csc_n, ps_n, cs_n, step_n, gw_n, bwe_n} = 8'hbf;
    {lane_n, addr, drv_q, base} = '0;
    lane_n = 2'h3;
    failures = 0;
    comparisons = 0;
    inval_cnt = 0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    for (int o = 1; o >= 0; o--) begin
      mode = 1'(o);
      base = 18'($random(seed)) & 18'h3fffc;
      idle(6);
      for (int k = 0; k < 4; k++) wr(k, 18'($random(seed)), 4'h7, k[0]);
      for (int s = 0; s < 4; s++) rd(2'(s));
    end
    for (int k = 0; k < 4; k++) wr(k, 18'($random(seed)), wtab[k], 1'b0);
    repeat (10) wr(int'($random(seed)) & 3, 18'($random(seed)),
                   4'($random(seed)), 1'($random(seed)));
    start({base[17:2], 2'h2}, 18'h1234, 1'b0, 1'b0, 4'h0);
    idle(3);
    rd(2'h1);
    slp = 1'b1;
    idle(10);
    cmp("asleep", 18'h1, {17'h0, asleep});
    cmp("invalid", 18'h1, 18'(inval_cnt));
    slp = 1'b0;
    idle(10);
    cmp("awake", 18'h0, {17'h0, asleep});
    rd(2'h3);
    final_report();
  end
  // count invalid pulses; only sleep over an open burst may raise one
  always @(negedge clk) begin
    if (inval === 1'b1) inval_cnt++;
  end
  initial begin
    #1000000;
    failures++;
    final_report();
  end
endmodule : sync_burst_sram_control_bench
`default_nettype wire
